// ===== verilog/pphy_defs.svh
`ifndef PPHY_DEFS_SVH
`define PPHY_DEFS_SVH

// Register indices; byte address is four times the index
`define PPHY_IDX_CTRL 6'h02
`define PPHY_IDX_STD_CTRL 6'h04
`define PPHY_IDX_STD_ADV 6'h05
`define PPHY_IDX_STATUS 6'h06
`define PPHY_ADDR_CTRL {`PPHY_IDX_CTRL, 2'b00}
`define PPHY_ADDR_STD_CTRL {`PPHY_IDX_STD_CTRL, 2'b00}
`define PPHY_ADDR_STD_ADV {`PPHY_IDX_STD_ADV, 2'b00}
`define PPHY_ADDR_STATUS {`PPHY_IDX_STATUS, 2'b00}

// Reset value of the control register
`define PPHY_CTRL_RESET 16'h009f

// Field positions in the control register
`define PPHY_B_LED_OFF 15
`define PPHY_B_TX_DIS 14
`define PPHY_B_AN_RESTART 13
`define PPHY_B_RSVD 12
`define PPHY_B_PWR_DOWN 11
`define PPHY_B_MDIX_DIS 10
`define PPHY_B_MDIX_FORCE 9
`define PPHY_B_FAR_LOOP 8
`define PPHY_B_AN_EN 7
`define PPHY_B_SPEED 6
`define PPHY_B_DUPLEX 5
`define PPHY_B_ADV_PAUSE 4
`define PPHY_B_ADV_100FD 3
`define PPHY_B_ADV_100HD 2
`define PPHY_B_ADV_10FD 1
`define PPHY_B_ADV_10HD 0

// Field positions in the standard control view
`define PPHY_S_LED_OFF 0
`define PPHY_S_TX_DIS 1
`define PPHY_S_RSVD 2
`define PPHY_S_MDIX_DIS 3
`define PPHY_S_MDIX_FORCE 4
`define PPHY_S_DUPLEX 8
`define PPHY_S_AN_RESTART 9
`define PPHY_S_PWR_DOWN 11
`define PPHY_S_AN_EN 12
`define PPHY_S_SPEED 13
`define PPHY_S_FAR_LOOP 14

// Field positions in the standard advertisement view
`define PPHY_A_10HD 5
`define PPHY_A_10FD 6
`define PPHY_A_100HD 7
`define PPHY_A_100FD 8
`define PPHY_A_PAUSE 10

// Field positions in the status register
`define PPHY_ST_AN_DONE 0
`define PPHY_ST_AN_FAIL 1
`define PPHY_ST_SPEED 2
`define PPHY_ST_DUPLEX 3
`define PPHY_ST_MDIX 4

`endif

// ===== verilog/pphy_pkg.sv
`default_nettype none
package pphy_pkg;
    typedef logic [15:0] pphy_word_t;
    // Decoded register select, one-hot
    typedef enum logic [4:0] {
        PPHY_SEL_NONE = 5'b0_0001,
        PPHY_SEL_CTRL = 5'b0_0010,
        PPHY_SEL_STD_CTRL = 5'b0_0100,
        PPHY_SEL_STD_ADV = 5'b0_1000,
        PPHY_SEL_STATUS = 5'b1_0000
    } pphy_sel_e;
endpackage
`default_nettype wire

// ===== verilog/pphy_avs_hs.sv
`timescale 1ns/1ps
`default_nettype none
// Avalon handshake: one wait cycle, then one cycle with waitrequest low
module pphy_avs_hs (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    output var logic waitrequest,
    output logic first,
    output logic commit
);
    // Low for exactly one cycle per request; high at rest and in reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if (req && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // First cycle decodes, commit cycle completes the transfer
    assign first = req & waitrequest;
    assign commit = req & ~waitrequest;
endmodule
`default_nettype wire

// ===== verilog/pphy_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pphy_defs.svh"
module pphy_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output var logic [31:0] readdata,
    output var logic waitrequest,
    input wire logic [3:0] led_raw,
    input wire logic an_done,
    input wire logic an_failed,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic mdix_active,
    output var logic port_two_led_three,
    output var logic port_two_led_two,
    output var logic port_two_led_one,
    output var logic port_two_led_zero,
    output var logic tx_disable,
    output var logic an_restart,
    output var logic power_down,
    output var logic mdix_auto_en,
    output var logic mdix_force,
    output var logic far_loopback,
    output var logic speed_100,
    output var logic full_duplex,
    output var logic adv_pause,
    output var logic [3:0] adv_modes
);
    pphy_pkg::pphy_word_t ctrl_reg;
    pphy_pkg::pphy_word_t wr_mask;
    pphy_pkg::pphy_word_t wr_data;
    pphy_pkg::pphy_word_t rd_word;
    pphy_pkg::pphy_word_t be_mask;
    pphy_pkg::pphy_word_t wd16;
    pphy_pkg::pphy_sel_e sel;
    logic [3:0] led_reg;
    logic first;
    logic commit;

    // Standard control view into native layout
    function automatic pphy_pkg::pphy_word_t std_to_native(input pphy_pkg::pphy_word_t s);
        pphy_pkg::pphy_word_t n;
        n = 16'h0000;
        n[`PPHY_B_LED_OFF] = s[`PPHY_S_LED_OFF];
        n[`PPHY_B_TX_DIS] = s[`PPHY_S_TX_DIS];
        n[`PPHY_B_AN_RESTART] = s[`PPHY_S_AN_RESTART];
        n[`PPHY_B_RSVD] = s[`PPHY_S_RSVD];
        n[`PPHY_B_PWR_DOWN] = s[`PPHY_S_PWR_DOWN];
        n[`PPHY_B_MDIX_DIS] = s[`PPHY_S_MDIX_DIS];
        n[`PPHY_B_MDIX_FORCE] = s[`PPHY_S_MDIX_FORCE];
        n[`PPHY_B_FAR_LOOP] = s[`PPHY_S_FAR_LOOP];
        n[`PPHY_B_AN_EN] = s[`PPHY_S_AN_EN];
        n[`PPHY_B_SPEED] = s[`PPHY_S_SPEED];
        n[`PPHY_B_DUPLEX] = s[`PPHY_S_DUPLEX];
        return n;
    endfunction

    // Native layout into standard control view
    function automatic pphy_pkg::pphy_word_t native_to_std(input pphy_pkg::pphy_word_t n);
        pphy_pkg::pphy_word_t s;
        s = 16'h0000;
        s[`PPHY_S_LED_OFF] = n[`PPHY_B_LED_OFF];
        s[`PPHY_S_TX_DIS] = n[`PPHY_B_TX_DIS];
        s[`PPHY_S_AN_RESTART] = n[`PPHY_B_AN_RESTART];
        s[`PPHY_S_RSVD] = n[`PPHY_B_RSVD];
        s[`PPHY_S_PWR_DOWN] = n[`PPHY_B_PWR_DOWN];
        s[`PPHY_S_MDIX_DIS] = n[`PPHY_B_MDIX_DIS];
        s[`PPHY_S_MDIX_FORCE] = n[`PPHY_B_MDIX_FORCE];
        s[`PPHY_S_FAR_LOOP] = n[`PPHY_B_FAR_LOOP];
        s[`PPHY_S_AN_EN] = n[`PPHY_B_AN_EN];
        s[`PPHY_S_SPEED] = n[`PPHY_B_SPEED];
        s[`PPHY_S_DUPLEX] = n[`PPHY_B_DUPLEX];
        return s;
    endfunction

    // Advertisement view into native layout
    function automatic pphy_pkg::pphy_word_t adv_to_native(input pphy_pkg::pphy_word_t a);
        pphy_pkg::pphy_word_t n;
        n = 16'h0000;
        n[`PPHY_B_ADV_PAUSE] = a[`PPHY_A_PAUSE];
        n[`PPHY_B_ADV_100FD] = a[`PPHY_A_100FD];
        n[`PPHY_B_ADV_100HD] = a[`PPHY_A_100HD];
        n[`PPHY_B_ADV_10FD] = a[`PPHY_A_10FD];
        n[`PPHY_B_ADV_10HD] = a[`PPHY_A_10HD];
        return n;
    endfunction

    // Native layout into advertisement view
    function automatic pphy_pkg::pphy_word_t native_to_adv(input pphy_pkg::pphy_word_t n);
        pphy_pkg::pphy_word_t a;
        a = 16'h0000;
        a[`PPHY_A_PAUSE] = n[`PPHY_B_ADV_PAUSE];
        a[`PPHY_A_100FD] = n[`PPHY_B_ADV_100FD];
        a[`PPHY_A_100HD] = n[`PPHY_B_ADV_100HD];
        a[`PPHY_A_10FD] = n[`PPHY_B_ADV_10FD];
        a[`PPHY_A_10HD] = n[`PPHY_B_ADV_10HD];
        return a;
    endfunction

    // Bus handshake: fixed one wait cycle per transfer
    pphy_avs_hs u_hs (
        .clk(clk),
        .rst(rst),
        .req(read | write),
        .waitrequest(waitrequest),
        .first(first),
        .commit(commit)
    );

    // Address decode; unmapped words read zero and ignore writes
    always_comb begin
        unique case (address)
            `PPHY_ADDR_CTRL: sel = pphy_pkg::PPHY_SEL_CTRL;
            `PPHY_ADDR_STD_CTRL: sel = pphy_pkg::PPHY_SEL_STD_CTRL;
            `PPHY_ADDR_STD_ADV: sel = pphy_pkg::PPHY_SEL_STD_ADV;
            `PPHY_ADDR_STATUS: sel = pphy_pkg::PPHY_SEL_STATUS;
            default: sel = pphy_pkg::PPHY_SEL_NONE;
        endcase
    end

    // Byte lanes 0 and 1 carry the 16-bit word; lanes 2 and 3 are ignored
    assign be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
    assign wd16 = writedata[15:0];

    // Every view is folded into one native mask and data
    always_comb begin
        wr_mask = 16'h0000;
        wr_data = 16'h0000;
        if (commit && write) begin
            unique case (sel)
                pphy_pkg::PPHY_SEL_CTRL: begin
                    wr_mask = be_mask;
                    wr_data = wd16;
                end
                pphy_pkg::PPHY_SEL_STD_CTRL: begin
                    wr_mask = std_to_native(be_mask);
                    wr_data = std_to_native(wd16);
                end
                pphy_pkg::PPHY_SEL_STD_ADV: begin
                    wr_mask = adv_to_native(be_mask);
                    wr_data = adv_to_native(wd16);
                end
                pphy_pkg::PPHY_SEL_STATUS,
                pphy_pkg::PPHY_SEL_NONE: begin
                    wr_mask = 16'h0000;
                    wr_data = 16'h0000;
                end
            endcase
        end
    end

    // Single storage behind all views, so all three views always agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `PPHY_CTRL_RESET;
        end else begin
            ctrl_reg <= (ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // Read word for the selected view
    always_comb begin
        rd_word = 16'h0000;
        unique case (sel)
            pphy_pkg::PPHY_SEL_CTRL: rd_word = ctrl_reg;
            pphy_pkg::PPHY_SEL_STD_CTRL: rd_word = native_to_std(ctrl_reg);
            pphy_pkg::PPHY_SEL_STD_ADV: rd_word = native_to_adv(ctrl_reg);
            pphy_pkg::PPHY_SEL_STATUS: begin
                rd_word[`PPHY_ST_AN_DONE] = an_done;
                rd_word[`PPHY_ST_AN_FAIL] = an_failed;
                rd_word[`PPHY_ST_SPEED] = speed_100;
                rd_word[`PPHY_ST_DUPLEX] = full_duplex;
                rd_word[`PPHY_ST_MDIX] = mdix_active;
            end
            pphy_pkg::PPHY_SEL_NONE: rd_word = 16'h0000;
        endcase
    end

    // Read data captured in the wait cycle, held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (first && read) begin
            readdata <= {16'h0000, rd_word};
        end
    end

    // LED blanking forces every pin high, otherwise the raw activity shows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_reg <= 4'hf;
        end else if (ctrl_reg[`PPHY_B_LED_OFF]) begin
            led_reg <= 4'hf;
        end else begin
            led_reg <= led_raw;
        end
    end
    assign port_two_led_three = led_reg[3];
    assign port_two_led_two = led_reg[2];
    assign port_two_led_one = led_reg[1];
    assign port_two_led_zero = led_reg[0];

    // Restart pulse on any write of one, so a repeated write restarts again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            an_restart <= 1'b0;
        end else begin
            an_restart <= wr_mask[`PPHY_B_AN_RESTART] & wr_data[`PPHY_B_AN_RESTART];
        end
    end

    // Static transceiver controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_disable <= 1'b0;
            power_down <= 1'b0;
            far_loopback <= 1'b0;
        end else begin
            tx_disable <= ctrl_reg[`PPHY_B_TX_DIS];
            power_down <= ctrl_reg[`PPHY_B_PWR_DOWN];
            far_loopback <= ctrl_reg[`PPHY_B_FAR_LOOP];
        end
    end

    // Crossover: forcing only counts while automatic detection is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdix_auto_en <= 1'b1;
            mdix_force <= 1'b0;
        end else begin
            mdix_auto_en <= ~ctrl_reg[`PPHY_B_MDIX_DIS];
            mdix_force <= ctrl_reg[`PPHY_B_MDIX_DIS] & ctrl_reg[`PPHY_B_MDIX_FORCE];
        end
    end

    // Speed and duplex resolution; a failed negotiation falls back to bit 5
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
        end else begin
            if (ctrl_reg[`PPHY_B_AN_EN]) begin
                speed_100 <= an_speed_100;
            end else begin
                speed_100 <= ctrl_reg[`PPHY_B_SPEED];
            end
            if (ctrl_reg[`PPHY_B_AN_EN] && !an_failed) begin
                full_duplex <= an_full_duplex;
            end else begin
                full_duplex <= ctrl_reg[`PPHY_B_DUPLEX];
            end
        end
    end

    // Advertised abilities
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adv_pause <= 1'b1;
            adv_modes <= 4'hf;
        end else begin
            adv_pause <= ctrl_reg[`PPHY_B_ADV_PAUSE];
            adv_modes <= ctrl_reg[`PPHY_B_ADV_100FD:`PPHY_B_ADV_10HD];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_led_blank: assert property (
        ctrl_reg[`PPHY_B_LED_OFF] |=> (port_two_led_three && port_two_led_two
            && port_two_led_one && port_two_led_zero))
        else $error("LEDs not blanked high");
    chk_led_normal: assert property (
        !ctrl_reg[`PPHY_B_LED_OFF] |=> led_reg == $past(led_raw))
        else $error("LEDs do not follow activity");
    chk_tx_disable_write: assert property (
        (commit && write && sel == pphy_pkg::PPHY_SEL_CTRL && byteenable[1])
        |=> ##1 tx_disable == $past(writedata[14], 2))
        else $error("Transmitter disable not updated by write");
    chk_restart_pulse: assert property (
        (commit && write && sel == pphy_pkg::PPHY_SEL_CTRL && byteenable[1] && writedata[13])
        |=> an_restart ##1 !an_restart)
        else $error("Restart pulse wrong");
    chk_restart_cause: assert property (
        an_restart |-> $past(commit && write))
        else $error("Restart without write");
    chk_mdix_auto: assert property (
        mdix_auto_en == !$past(ctrl_reg[`PPHY_B_MDIX_DIS]))
        else $error("Auto crossover enable wrong");
    chk_mdix_force: assert property (
        mdix_force |-> $past(ctrl_reg[`PPHY_B_MDIX_DIS] && ctrl_reg[`PPHY_B_MDIX_FORCE]))
        else $error("MDI-X forced without cause");
    chk_far_loop: assert property (
        far_loopback == $past(ctrl_reg[`PPHY_B_FAR_LOOP]))
        else $error("Loopback enable wrong");
    chk_speed_forced: assert property (
        !ctrl_reg[`PPHY_B_AN_EN] |=> speed_100 == $past(ctrl_reg[`PPHY_B_SPEED]))
        else $error("Forced speed wrong");
    chk_speed_auto: assert property (
        ctrl_reg[`PPHY_B_AN_EN] |=> speed_100 == $past(an_speed_100))
        else $error("Negotiated speed wrong");
    chk_duplex_fallback: assert property (
        (!ctrl_reg[`PPHY_B_AN_EN] || an_failed)
        |=> full_duplex == $past(ctrl_reg[`PPHY_B_DUPLEX]))
        else $error("Forced duplex wrong");
    chk_adv_pause: assert property (
        adv_pause == $past(ctrl_reg[`PPHY_B_ADV_PAUSE]))
        else $error("Pause advertisement wrong");
    chk_adv_modes: assert property (
        adv_modes == $past(ctrl_reg[3:0]))
        else $error("Mode advertisement wrong");
    chk_power_down: assert property (
        power_down == $past(ctrl_reg[`PPHY_B_PWR_DOWN]))
        else $error("Power-down wrong");
    chk_view_share: assert property (
        (commit && write && sel == pphy_pkg::PPHY_SEL_STD_CTRL && byteenable[1])
        |=> ctrl_reg[`PPHY_B_PWR_DOWN] == $past(writedata[`PPHY_S_PWR_DOWN]))
        else $error("Standard view write not seen natively");
    chk_one_wait: assert property (
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("Handshake timing wrong");
endmodule
`default_nettype wire

// ===== testbench/pphy_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural transceiver standing on the far side of the control block
module pphy_xcvr_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic an_restart,
    input wire logic mdix_force,
    input wire logic lnk_fast,
    input wire logic lnk_full,
    input wire logic lnk_fail,
    output var logic [3:0] led_raw,
    output var logic an_done,
    output var logic an_failed,
    output var logic an_speed_100,
    output var logic an_full_duplex,
    output var logic mdix_active
);
    logic [2:0] an_cnt_reg;
    // LED levels change every cycle so a stale copy cannot pass
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_raw <= 4'h5;
        end else begin
            led_raw <= {led_raw[2:0], ~led_raw[3]};
        end
    end
    // Negotiation is busy for a few cycles after each restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            an_cnt_reg <= 3'h0;
        end else if (an_restart) begin
            an_cnt_reg <= 3'h4;
        end else if (an_cnt_reg != 3'h0) begin
            an_cnt_reg <= an_cnt_reg - 3'h1;
        end
    end
    // Results only stand once negotiation has finished
    assign an_done = (an_cnt_reg == 3'h0);
    assign an_failed = an_done & lnk_fail;
    assign an_speed_100 = an_done & lnk_fast;
    assign an_full_duplex = an_done & lnk_full & ~lnk_fail;
    assign mdix_active = mdix_force;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pphy_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    logic clk, rst, read, write, lnk_fast, lnk_full, lnk_fail;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable, led_raw, adv_modes;
    logic waitrequest, an_done, an_failed, an_speed_100, an_full_duplex, mdix_active;
    logic led3, led2, led1, led0, tx_disable, an_restart, power_down, mdix_auto_en;
    logic mdix_force, far_loopback, speed_100, full_duplex, adv_pause;
    int error_cnt = 0;
    int n_compared = 0;
    logic [15:0] rd;
    logic [3:0] prev;
    int pulses;

    pphy_ctrl i_pphy_ctrl (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .led_raw(led_raw),
        .an_done(an_done), .an_failed(an_failed), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .mdix_active(mdix_active),
        .port_two_led_three(led3), .port_two_led_two(led2), .port_two_led_one(led1),
        .port_two_led_zero(led0), .tx_disable(tx_disable), .an_restart(an_restart),
        .power_down(power_down), .mdix_auto_en(mdix_auto_en), .mdix_force(mdix_force),
        .far_loopback(far_loopback), .speed_100(speed_100), .full_duplex(full_duplex),
        .adv_pause(adv_pause), .adv_modes(adv_modes));
    pphy_xcvr_model i_pphy_xcvr_model (.clk(clk), .rst(rst), .an_restart(an_restart),
        .mdix_force(mdix_force), .lnk_fast(lnk_fast), .lnk_full(lnk_full),
        .lnk_fail(lnk_fail), .led_raw(led_raw), .an_done(an_done), .an_failed(an_failed),
        .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
        .mdix_active(mdix_active));

    // 100 MHz system clock
    always #5 clk = ~clk;

    // Hold the request until waitrequest is seen low; only the watchdog ends a hang
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
            input logic [3:0] be);
        @(posedge clk);
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata[15:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        bus_xfer(1'b1, a, d, 4'hf);
    endtask

    task automatic rd16(input logic [7:0] a);
        bus_xfer(1'b0, a, 16'h0000, 4'hf);
    endtask

    // Transceiver controls expected from a control word
    function automatic logic [9:0] exp_out(input logic [15:0] c);
        return {c[14], c[11], ~c[10], c[10] & c[9], c[8], c[4], c[3:0]};
    endfunction

    task automatic t_reset();
        rd16(`PPHY_ADDR_CTRL);
        `CHK(rd, 16'h009f)
        `CHK({adv_pause, adv_modes}, 5'h1f)
    endtask

    task automatic t_ctrl_bits();
        logic [15:0] w[9] = '{16'h4000, 16'h0800, 16'h0400, 16'h0600, 16'h0200,
            16'h0100, 16'h0010, 16'h000a, 16'h0000};
        logic [9:0] got;
        foreach (w[i]) begin
            wr16(`PPHY_ADDR_CTRL, w[i] | 16'h0080);
            @(posedge clk);
            #1;
            got = {tx_disable, power_down, mdix_auto_en, mdix_force, far_loopback,
                adv_pause, adv_modes};
            `CHK(got, exp_out(w[i]))
            rd16(`PPHY_ADDR_CTRL);
            `CHK(rd, w[i] | 16'h0080)
        end
    endtask

    task automatic t_led();
        wr16(`PPHY_ADDR_CTRL, 16'h809f);
        @(posedge clk);
        repeat (4) begin
            @(posedge clk);
            #1;
            `CHK({led3, led2, led1, led0}, 4'hf)
        end
        wr16(`PPHY_ADDR_CTRL, 16'h009f);
        @(posedge clk);
        repeat (4) begin
            @(posedge clk);
            prev = led_raw;
            #1;
            `CHK({led3, led2, led1, led0}, prev)
        end
    endtask

    // Forced values against negotiated ones, including a failed negotiation
    task automatic t_speed();
        lnk_fast <= 1'b1;
        lnk_full <= 1'b1;
        wr16(`PPHY_ADDR_CTRL, 16'h0000);
        @(posedge clk);
        #1;
        `CHK({speed_100, full_duplex}, 2'h0)
        wr16(`PPHY_ADDR_CTRL, 16'h0060);
        lnk_fast <= 1'b0;
        lnk_full <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({speed_100, full_duplex}, 2'h3)
        wr16(`PPHY_ADDR_CTRL, 16'h0080);
        lnk_fast <= 1'b1;
        lnk_full <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK({speed_100, full_duplex}, 2'h3)
        lnk_fail <= 1'b1;
        wr16(`PPHY_ADDR_CTRL, 16'h00a0);
        @(posedge clk);
        #1;
        `CHK(full_duplex, 1'b1)
        wr16(`PPHY_ADDR_CTRL, 16'h0080);
        @(posedge clk);
        #1;
        `CHK(full_duplex, 1'b0)
        lnk_fail <= 1'b0;
        // Status shows negotiation done, 100 Mbit/s, full duplex, no forced MDI-X
        rd16(`PPHY_ADDR_STATUS);
        `CHK(rd, 16'h000d)
    endtask

    // Every write of one gives exactly one pulse, a repeated write too
    task automatic t_restart();
        repeat (2) begin
            wr16(`PPHY_ADDR_CTRL, 16'h2080);
            pulses = 0;
            repeat (6) begin
                @(posedge clk);
                pulses += int'(an_restart === 1'b1);
            end
            `CHK(pulses, 1)
        end
        wr16(`PPHY_ADDR_CTRL, 16'h009f);
    endtask

    // Shared storage across the views, byte lanes and an unmapped word
    task automatic t_views();
        wr16(`PPHY_ADDR_STD_CTRL, 16'h1001);
        rd16(`PPHY_ADDR_CTRL);
        `CHK(rd, 16'h809f)
        wr16(`PPHY_ADDR_STD_ADV, 16'h0400);
        rd16(`PPHY_ADDR_CTRL);
        `CHK(rd, 16'h8090)
        wr16(`PPHY_ADDR_CTRL, 16'h4080);
        rd16(`PPHY_ADDR_STD_CTRL);
        `CHK(rd, 16'h1002)
        bus_xfer(1'b1, `PPHY_ADDR_CTRL, 16'hffff, 4'h1);
        rd16(`PPHY_ADDR_CTRL);
        `CHK(rd, 16'h40ff)
        wr16(8'h3c, 16'hffff);
        rd16(8'h3c);
        `CHK(rd, 16'h0000)
        rd16(`PPHY_ADDR_CTRL);
        `CHK(rd, 16'h40ff)
    endtask

    task automatic give_verdict();
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        lnk_fast = 1'b0;
        lnk_full = 1'b0;
        lnk_fail = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctrl_bits();
        t_led();
        t_speed();
        t_restart();
        t_views();
        give_verdict();
    end
endmodule
`default_nettype wire
